// ===== pwg_defines.svh
/*
 * constants for the pulse generator block: register word indices,
 * field positions and reset values.
 * assumes it is included by the package and by every design module.
 */
// Function
// [R01] two groups give eight channels or pairs
// [R02] 8-bit prescaler then divider 1 to 1/16
// [R03] 16-bit down counters and 16-bit comparators
// [R04] zero sets period flag, enable gates irq
// [R05] auto-reload reloads; one-shot stops at zero
// [R06] pair dead-zone bit makes even timer drive pair
// [R07] period and compare load from buffers at zero
// [R08] output goes high when counter equals compare
// [R09] capture enable turns pin into input
// [R10] software sets timer before enabling capture
// [R11] rising edge latches counter, falling edge too
// [R12] separate rise and fall capture irq enables
// [R13] capture interrupt reloads that channel counter
// [R14] each channel has its own capture flag
// [R15] writing one clears the indicator bit
// [R16] edge-aligned or center-aligned counting selectable
// [R17] timer zero can start the converter
// [R18] dead-zone delays rising edges, never both high
`ifndef PWG_DEFINES_SVH
`define PWG_DEFINES_SVH
`define PWG_GRP_BIT 7
`define PWG_WORD_HI 6
`define PWG_WORD_LO 2
`define PWG_W_PRESC 5'h00
`define PWG_W_DIV 5'h01
`define PWG_W_PCR 5'h02
`define PWG_W_PER0 5'h03
`define PWG_W_CMP0 5'h07
`define PWG_W_DZ 5'h0B
`define PWG_W_STAT 5'h0C
`define PWG_W_CCRL 5'h0D
`define PWG_W_CCRH 5'h0E
`define PWG_W_MASK 5'h0F
`define PWG_W_RISE0 5'h10
`define PWG_W_FALL0 5'h14
`define PWG_W_LAST 5'h17
`define PWG_PCR_FLD 8
`define PWG_PCR_RUN 0
`define PWG_PCR_ADC 1
`define PWG_PCR_CENTER 2
`define PWG_PCR_AUTO 3
`define PWG_PCR_DZ0 4
`define PWG_CCR_FLD 16
`define PWG_CCR_RISE_IE 1
`define PWG_CCR_FALL_IE 2
`define PWG_CCR_CAP_EN 3
`define PWG_DIV_FLD 4
`define PWG_PRE_FLD 8
`define PWG_DZ_FLD 8
`define PWG_CAP_LSB 4
`define PWG_RST8 8'h00
`define PWG_RST16 16'h0000
`define PWG_RST32 32'h0000_0000
`define PWG_ONE16 16'h0001
`endif

// ===== pwg_pkg.sv
/*
 * types shared by the pulse generator modules.
 * assumes pwg_defines.svh is on the include path.
 */
`include "pwg_defines.svh"
package pwg_pkg;
   // per-channel settings taken from the register file
   typedef struct packed {
      logic run;
      logic auto_reload;
      logic center;
      logic cap_en;
      logic rise_ie;
      logic fall_ie;
      logic [2:0] div_sel;
      logic [15:0] period;
      logic [15:0] cmp;
   } pwg_chan_cfg_t;
   // per-channel results, all from flops
   typedef struct packed {
      logic out;
      logic zero;
      logic cap_irq;
      logic [15:0] rise;
      logic [15:0] fall;
   } pwg_chan_stat_t;
   typedef enum logic [1:0] {CNT_IDLE, CNT_DOWN, CNT_UP, CNT_DONE} pwg_cnt_state_t;
endpackage

// ===== pwg_chan.sv
/*
 * one timer channel: divider, 16-bit down/up counter, comparator,
 * capture latches.
 * assumes the prescaler tick and a synchronous capture pin level.
 */
`timescale 1ns/1ns
`include "pwg_defines.svh"
module pwg_chan import pwg_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic pre_tick,
   input wire pwg_chan_cfg_t cfg,
   input wire logic cap_pin,
   output pwg_chan_stat_t stat
);
   logic [3:0] div_reg; // divider count
   logic [3:0] div_mask; // low bits that must be all ones
   logic tick; // counting step
   logic [15:0] cnt_reg, per_act_reg, cmp_act_reg, rise_reg, fall_reg;
   logic out_reg, zero_reg, cap_irq_reg, pin_d_reg;
   logic rise_ev, fall_ev, cap_ev;
   pwg_cnt_state_t st_reg;

   // ratio select; codes above three act as 1/16
   always_comb begin
      case (cfg.div_sel)
         3'h0: div_mask = 4'h0;
         3'h1: div_mask = 4'h1;
         3'h2: div_mask = 4'h3;
         3'h3: div_mask = 4'h7;
         default: div_mask = 4'hF;
      endcase
   end
   assign tick = pre_tick && ((div_reg & div_mask) == div_mask); // see [R02]

   // divider free-runs only while the channel runs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) div_reg <= 4'h0;
      else if (!cfg.run) div_reg <= 4'h0;
      else if (pre_tick) div_reg <= div_reg + 4'h1; // see [R02]
   end

   // capture edges, pin already synchronous
   assign rise_ev = cfg.cap_en && cap_pin && !pin_d_reg;
   assign fall_ev = cfg.cap_en && !cap_pin && pin_d_reg;
   assign cap_ev = (rise_ev && cfg.rise_ie) || (fall_ev && cfg.fall_ie); // see [R12]

   // latches and capture irq pulse
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_d_reg <= 1'b0;
         rise_reg <= `PWG_RST16;
         fall_reg <= `PWG_RST16;
         cap_irq_reg <= 1'b0;
      end else begin
         pin_d_reg <= cap_pin;
         cap_irq_reg <= cap_ev; // see [R14]
         if (rise_ev) rise_reg <= cnt_reg; // see [R11]
         if (fall_ev) fall_reg <= cnt_reg; // see [R11]
      end
   end

   // counter; a capture interrupt outranks the tick
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= CNT_IDLE;
         cnt_reg <= `PWG_RST16;
         per_act_reg <= `PWG_RST16;
         cmp_act_reg <= `PWG_RST16;
         out_reg <= 1'b0;
         zero_reg <= 1'b0;
      end else begin
         zero_reg <= 1'b0;
         if (!cfg.run) begin
            st_reg <= CNT_IDLE;
            out_reg <= 1'b0;
         end else begin
            case (st_reg)
               CNT_IDLE: begin
                  per_act_reg <= cfg.period;
                  cmp_act_reg <= cfg.cmp;
                  cnt_reg <= cfg.period; // see [R03]
                  out_reg <= 1'b0;
                  st_reg <= CNT_DOWN;
               end
               CNT_DOWN: begin
                  if (cap_ev) cnt_reg <= per_act_reg; // see [R13]
                  else if (tick) begin
                     if (cnt_reg == `PWG_RST16) begin
                        zero_reg <= 1'b1; // see [R04]
                        per_act_reg <= cfg.period; // see [R07]
                        cmp_act_reg <= cfg.cmp; // see [R07]
                        if (!cfg.center) out_reg <= 1'b0;
                        if (!cfg.auto_reload) st_reg <= CNT_DONE; // see [R05]
                        else if (cfg.center) st_reg <= CNT_UP; // see [R16]
                        else cnt_reg <= cfg.period; // see [R05]
                     end else begin
                        cnt_reg <= cnt_reg - `PWG_ONE16;
                        if (cnt_reg == cmp_act_reg) out_reg <= 1'b1; // see [R08]
                     end
                  end
               end
               CNT_UP: begin
                  // rising half of a center-aligned cycle
                  if (cap_ev) begin
                     cnt_reg <= per_act_reg; // see [R13]
                     st_reg <= CNT_DOWN;
                  end else if (tick) begin
                     if (cnt_reg == cmp_act_reg) out_reg <= 1'b0; // see [R16]
                     if (cnt_reg >= per_act_reg) begin
                        st_reg <= CNT_DOWN;
                        cnt_reg <= cnt_reg - `PWG_ONE16;
                     end else cnt_reg <= cnt_reg + `PWG_ONE16;
                  end
               end
               CNT_DONE: out_reg <= 1'b0; // one-shot ends here until run drops
               default: st_reg <= CNT_IDLE;
            endcase
         end
      end
   end

   assign stat = '{out: out_reg, zero: zero_reg, cap_irq: cap_irq_reg,
                   rise: rise_reg, fall: fall_reg};

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_zero_reload: assert property (cfg.run && st_reg == CNT_DOWN && tick && !cap_ev
      && cnt_reg == `PWG_RST16 && cfg.auto_reload && !cfg.center && $stable(cfg.run)
      |=> cnt_reg == $past(cfg.period)) else $error("no reload at zero"); // see [R05]
   a_oneshot_stop: assert property (cfg.run && st_reg == CNT_DOWN && tick && !cap_ev
      && cnt_reg == `PWG_RST16 && !cfg.auto_reload
      |=> !cfg.run || (st_reg == CNT_DONE && !out_reg)) else $error("one-shot ran on"); // see [R05]
   a_match_high: assert property (cfg.run && st_reg == CNT_DOWN && tick && !cap_ev
      && cnt_reg != `PWG_RST16 && cnt_reg == cmp_act_reg
      |=> !cfg.run || out_reg) else $error("no high at match"); // see [R08]
   a_rise_latch: assert property (rise_ev |=> rise_reg == $past(cnt_reg))
      else $error("rise latch missed"); // see [R11]
   a_buffer_load: assert property (zero_reg |-> cmp_act_reg == $past(cfg.cmp))
      else $error("compare buffer not loaded"); // see [R07]
   a_cap_reload: assert property (cfg.run && $past(cfg.run) && cap_ev && st_reg == CNT_DOWN
      |=> !cfg.run || cnt_reg == $past(per_act_reg)) else $error("no capture reload"); // see [R13]
   c_auto_zero: cover property (zero_reg && cfg.auto_reload);
   c_capture: cover property (cap_irq_reg);
endmodule // pwg_chan

// ===== pwg_top.sv
/*
 * pulse generator top: two groups of four channels, apb register
 * file, prescalers, dead-zone logic, status, interrupt, adc trigger.
 * assumes apb signals and capture pins synchronous to core_clk.
 */
`timescale 1ns/1ns
`include "pwg_defines.svh"
module pwg_top import pwg_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] pwm_in,
   output logic [7:0] pwm_out,
   output logic [7:0] pwm_oe_n,
   output logic adc_start,
   output logic irq
);
   // register file, one entry per group unless noted; period and compare buffers are per channel
   logic [15:0] presc_reg [2]; // two 8-bit prescale values
   logic [15:0] div_reg [2]; // 4-bit ratio field per channel
   logic [31:0] pcr_reg [2]; // pulse_control_register
   logic [15:0] per_reg [8]; // period_reload_value buffers
   logic [15:0] cmp_reg [8]; // compare buffers
   logic [15:0] dz_reg [2]; // dead-zone counts per pair
   logic [31:0] ccr_reg [4]; // capture_control_low/high per group
   logic [7:0] mask_reg [2]; // interrupt mask
   logic [7:0] stat_reg [2]; // pulse_irq_indicator
   logic [31:0] prdata_reg; // read data taken in setup
   logic pslverr_reg;
   logic adc_reg;
   logic [7:0] rd_snap_reg; // status bits shown to the pending read

   pwg_chan_cfg_t cfg [8];
   pwg_chan_stat_t chst [8];
   logic [3:0] pre_tick;
   logic [7:0] raw_out;
   logic [7:0] dz_out_reg;
   logic [7:0] oe_n_reg;
   logic [31:0] rd_val;

   // address decode shared by read, write and error paths
   function automatic logic addr_ok(input logic [11:0] a);
      return (a[11:8] == 4'h0) && (a[1:0] == 2'b00)
         && (a[`PWG_WORD_HI:`PWG_WORD_LO] <= `PWG_W_LAST);
   endfunction

   logic [4:0] rw; // word within group
   logic rg; // group select
   logic wr_acc, rd_acc, setup;
   logic [4:0] per_off, cmp_off, rise_off, fall_off;
   assign rw = paddr[`PWG_WORD_HI:`PWG_WORD_LO];
   assign rg = paddr[`PWG_GRP_BIT];
   assign setup = psel && !penable;
   assign wr_acc = psel && penable && pwrite && addr_ok(paddr);
   assign rd_acc = psel && penable && !pwrite && addr_ok(paddr);
   assign per_off = rw - `PWG_W_PER0;
   assign cmp_off = rw - `PWG_W_CMP0;
   assign rise_off = rw - `PWG_W_RISE0;
   assign fall_off = rw - `PWG_W_FALL0;

   // zero wait: read data is already held from the setup cycle
   assign pready = 1'b1;
   assign prdata = prdata_reg;
   assign pslverr = pslverr_reg;

   // configuration writes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int g = 0; g < 2; g++) begin
            presc_reg[g] <= `PWG_RST16;
            div_reg[g] <= `PWG_RST16;
            pcr_reg[g] <= `PWG_RST32;
            dz_reg[g] <= `PWG_RST16;
            mask_reg[g] <= `PWG_RST8;
            ccr_reg[2*g] <= `PWG_RST32;
            ccr_reg[2*g+1] <= `PWG_RST32;
         end
         for (int c = 0; c < 8; c++) begin
            per_reg[c] <= `PWG_RST16;
            cmp_reg[c] <= `PWG_RST16;
         end
      end else if (wr_acc) begin
         case (rw)
            `PWG_W_PRESC: presc_reg[rg] <= pwdata[15:0];
            `PWG_W_DIV: div_reg[rg] <= pwdata[15:0];
            `PWG_W_PCR: pcr_reg[rg] <= pwdata;
            `PWG_W_DZ: dz_reg[rg] <= pwdata[15:0];
            `PWG_W_MASK: mask_reg[rg] <= pwdata[7:0];
            `PWG_W_CCRL: ccr_reg[{rg, 1'b0}] <= pwdata; // see [R12]
            `PWG_W_CCRH: ccr_reg[{rg, 1'b1}] <= pwdata; // see [R12]
            default: begin
               // buffer writes; active copies load at start and at zero
               if (rw >= `PWG_W_PER0 && rw < `PWG_W_CMP0)
                  per_reg[{rg, per_off[1:0]}] <= pwdata[15:0]; // see [R07]
               else if (rw >= `PWG_W_CMP0 && rw < `PWG_W_DZ)
                  cmp_reg[{rg, cmp_off[1:0]}] <= pwdata[15:0]; // see [R07]
            end
         endcase
      end
   end

   // read mux; unmapped words and bits above each register's stored width read zero
   always_comb begin
      rd_val = `PWG_RST32;
      case (rw)
         `PWG_W_PRESC: rd_val[15:0] = presc_reg[rg];
         `PWG_W_DIV: rd_val[15:0] = div_reg[rg];
         `PWG_W_PCR: rd_val = pcr_reg[rg];
         `PWG_W_DZ: rd_val[15:0] = dz_reg[rg];
         `PWG_W_STAT: rd_val[7:0] = stat_reg[rg];
         `PWG_W_MASK: rd_val[7:0] = mask_reg[rg];
         `PWG_W_CCRL: rd_val = ccr_reg[{rg, 1'b0}];
         `PWG_W_CCRH: rd_val = ccr_reg[{rg, 1'b1}];
         default: begin
            if (rw >= `PWG_W_PER0 && rw < `PWG_W_CMP0)
               rd_val[15:0] = per_reg[{rg, per_off[1:0]}];
            else if (rw >= `PWG_W_CMP0 && rw < `PWG_W_DZ)
               rd_val[15:0] = cmp_reg[{rg, cmp_off[1:0]}];
            else if (rw >= `PWG_W_RISE0 && rw < `PWG_W_FALL0)
               rd_val[15:0] = chst[{rg, rise_off[1:0]}].rise; // see [R11]
            else if (rw >= `PWG_W_FALL0 && rw <= `PWG_W_LAST)
               rd_val[15:0] = chst[{rg, fall_off[1:0]}].fall; // see [R11]
         end
      endcase
      if (!addr_ok(paddr)) rd_val = `PWG_RST32;
   end

   // setup cycle snapshot; error flagged for the access phase
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= `PWG_RST32;
         pslverr_reg <= 1'b0;
         rd_snap_reg <= `PWG_RST8;
      end else if (setup) begin
         prdata_reg <= pwrite ? `PWG_RST32 : rd_val;
         pslverr_reg <= !addr_ok(paddr);
         rd_snap_reg <= rd_val[7:0];
      end
   end

   // status flags: set wins; write-one and read both clear.
   // a read clears only what it showed, so a flag that rises
   // between setup and access is kept for the next read.
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_stat
         logic [7:0] set_v, clr_v;
         always_comb begin
            for (int k = 0; k < 4; k++) begin
               set_v[k] = chst[4*gi+k].zero; // see [R04]
               set_v[`PWG_CAP_LSB+k] = chst[4*gi+k].cap_irq; // see [R14]
            end
            clr_v = `PWG_RST8;
            if (wr_acc && rw == `PWG_W_STAT && rg == gi) clr_v = pwdata[7:0]; // see [R15]
            if (rd_acc && rw == `PWG_W_STAT && rg == gi) clr_v = rd_snap_reg;
         end
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) stat_reg[gi] <= `PWG_RST8;
            else stat_reg[gi] <= (stat_reg[gi] & ~clr_v) | set_v; // see [R15]
         end
      end
   endgenerate

   // one level interrupt from unmasked flags
   assign irq = |((stat_reg[0] & mask_reg[0]) | (stat_reg[1] & mask_reg[1])); // see [R04]

   // prescalers, one per generator pair
   generate
      for (gi = 0; gi < 4; gi++) begin : g_pre
         logic [7:0] pcnt_reg;
         logic [7:0] pval;
         assign pval = presc_reg[gi/2][`PWG_PRE_FLD*(gi%2) +: `PWG_PRE_FLD];
         assign pre_tick[gi] = (pcnt_reg == pval); // see [R02]
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) pcnt_reg <= `PWG_RST8;
            else if (pre_tick[gi]) pcnt_reg <= `PWG_RST8;
            else pcnt_reg <= pcnt_reg + 8'h01; // divide by value plus one
         end
      end
   endgenerate

   // eight channels in two groups
   generate
      for (gi = 0; gi < 8; gi++) begin : g_ch // see [R01]
         localparam int G = gi / 4;
         localparam int LC = gi % 4;
         localparam int EV = gi - (gi % 2);
         logic [7:0] pf;
         logic [15:0] cf;
         logic dz_en;
         logic src;
         logic [7:0] dzv;
         logic [7:0] dcnt_reg;
         assign pf = pcr_reg[G][`PWG_PCR_FLD*LC +: `PWG_PCR_FLD];
         assign cf = ccr_reg[2*G + LC/2][`PWG_CCR_FLD*(LC%2) +: `PWG_CCR_FLD];
         assign cfg[gi].run = pf[`PWG_PCR_RUN];
         assign cfg[gi].auto_reload = pf[`PWG_PCR_AUTO];
         assign cfg[gi].center = pf[`PWG_PCR_CENTER];
         assign cfg[gi].cap_en = cf[`PWG_CCR_CAP_EN];
         assign cfg[gi].rise_ie = cf[`PWG_CCR_RISE_IE];
         assign cfg[gi].fall_ie = cf[`PWG_CCR_FALL_IE];
         assign cfg[gi].div_sel = div_reg[G][`PWG_DIV_FLD*LC +: 3];
         assign cfg[gi].period = per_reg[gi];
         assign cfg[gi].cmp = cmp_reg[gi];

         pwg_chan u_chan (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .pre_tick(pre_tick[gi/2]),
            .cfg(cfg[gi]),
            .cap_pin(pwm_in[gi]),
            .stat(chst[gi])
         );
         assign raw_out[gi] = chst[gi].out;

         // pair mode: the even timer drives both pins
         assign dz_en = pcr_reg[G][`PWG_PCR_DZ0 + LC/2];
         assign dzv = dz_en ? dz_reg[G][`PWG_DZ_FLD*(LC/2) +: `PWG_DZ_FLD] : `PWG_RST8;
         if (gi % 2 == 0) begin : g_even
            assign src = raw_out[gi];
         end else begin : g_odd
            assign src = dz_en ? (cfg[EV].run && !raw_out[EV]) : raw_out[gi]; // see [R06]
         end

         // rising edges wait dzv extra cycles; falls pass at once,
         // so the two pins of a pair are never high together
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               dcnt_reg <= `PWG_RST8;
               dz_out_reg[gi] <= 1'b0;
            end else if (!src) begin
               dcnt_reg <= dzv; // see [R18]
               dz_out_reg[gi] <= 1'b0;
            end else if (dcnt_reg != `PWG_RST8) begin
               dcnt_reg <= dcnt_reg - 8'h01; // see [R18]
               dz_out_reg[gi] <= 1'b0;
            end else dz_out_reg[gi] <= 1'b1;
         end

         // capture mode releases the pin
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) oe_n_reg[gi] <= 1'b1;
            else oe_n_reg[gi] <= cfg[gi].cap_en; // see [R09]
         end
      end
   endgenerate

   assign pwm_out = dz_out_reg;
   assign pwm_oe_n = oe_n_reg;

   // converter start on zero of any channel that asks for it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) adc_reg <= 1'b0;
      else begin
         adc_reg <= 1'b0;
         for (int c = 0; c < 8; c++) begin
            if (chst[c].zero && pcr_reg[c/4][`PWG_PCR_FLD*(c%4) + `PWG_PCR_ADC])
               adc_reg <= 1'b1; // see [R17]
         end
      end
   end
   assign adc_start = adc_reg;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_period_irq: assert property (chst[0].zero && mask_reg[0][0] |=> irq)
      else $error("period irq missing"); // see [R04]
   a_w1c_clear: assert property (wr_acc && rw == `PWG_W_STAT && !rg && pwdata[0]
      && !chst[0].zero |=> !stat_reg[0][0]) else $error("flag not cleared"); // see [R15]
   a_set_wins: assert property (chst[1].zero |=> stat_reg[0][1])
      else $error("flag set lost"); // see [R04]
   a_adc_trig: assert property (chst[0].zero && pcr_reg[0][`PWG_PCR_ADC]
      |=> adc_start) else $error("no converter start"); // see [R17]
   a_dz_excl: assert property (pcr_reg[0][`PWG_PCR_DZ0] && $past(pcr_reg[0][`PWG_PCR_DZ0])
      |-> !(pwm_out[0] && pwm_out[1])) else $error("pair both high"); // see [R18]
   a_cap_oe: assert property (cfg[1].cap_en |=> pwm_oe_n[1])
      else $error("capture pin still driven"); // see [R09]
   a_bad_addr: assert property (setup && !addr_ok(paddr) |=> pslverr)
      else $error("unmapped access not flagged");
   c_irq: cover property (irq);
   c_pair: cover property (pcr_reg[0][`PWG_PCR_DZ0] && pwm_out[0] ##1 !pwm_out[0]);
endmodule // pwg_top

// ===== pwg_src_model.sv
/* far-side model: capture signal source sharing the channel pins.
   assumes src_lvl changes just after core_clk edges. */
`timescale 1ns/1ns
module pwg_src_model (
   input wire logic [7:0] src_lvl,
   input wire logic [7:0] pwm_out,
   input wire logic [7:0] pwm_oe_n,
   output logic [7:0] pwm_in
);
   // wire level: device drives while oe_n low, else the source
   assign pwm_in = (pwm_oe_n & src_lvl) | (~pwm_oe_n & pwm_out);
endmodule // pwg_src_model

// ===== tb_top.sv
/* self-checking bench for the pulse generator top.
   assumes the zero-wait apb slave and the pin model beside it. */
`timescale 1ns/1ns
module tb_top;
   import pwg_pkg::*;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, adc_start, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0] pwm_in, pwm_out, pwm_oe_n, src_lvl;
   logic err, seen;
   int miscompares, check_count, cyc, n;
   pwg_top dut (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pwm_in(pwm_in), .pwm_out(pwm_out),
      .pwm_oe_n(pwm_oe_n), .adc_start(adc_start), .irq(irq));
   pwg_src_model src (.src_lvl(src_lvl), .pwm_out(pwm_out), .pwm_oe_n(pwm_oe_n),
      .pwm_in(pwm_in));
   // clock, 100 ns period
   initial begin
      core_clk = 0;
      forever #50 core_clk = ~core_clk;
   end
   // hang guard, far above the few hundred cycles used
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (exp !== got) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer: setup, then access held until pready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // wait for irq, bounded; notes whether ch0 output rose meanwhile
   task automatic wait_irq;
      seen = 0;
      for (n = 0; n < 200 && irq !== 1'b1; n++) begin
         @(posedge core_clk);
         if (pwm_out[0] === 1'b1) seen = 1;
      end
      chk("irq", 1, irq);
   endtask
   task automatic t_reset;
      chk("oe_n", 8'hFF, pwm_oe_n);
      chk("irq", 0, irq);
      apb(0, 12'h030, 0);
      chk("status", 0, rd);
      apb(0, 12'h060, 0); // unmapped word
      chk("slverr", 1, err);
      chk("rdata", 0, rd);
      $display("test reset done");
   endtask
   // one-shot run of ch0, period 4, compare 2
   task automatic t_oneshot;
      apb(1, 12'h00C, 32'h0000_0004);
      apb(1, 12'h01C, 32'h0000_0002);
      apb(1, 12'h03C, 32'h0000_0001);
      apb(1, 12'h008, 32'h0000_0001);
      wait_irq();
      chk("out high", 1, seen);
      apb(1, 12'h030, 32'h0000_0001);
      // the clear lands at the access edge; look one edge later
      @(posedge core_clk);
      chk("irq clr", 0, irq);
      repeat (30) @(posedge core_clk);
      apb(0, 12'h030, 0);
      chk("stopped", 0, rd);
      $display("test oneshot done");
   endtask
   // auto-reload with converter trigger
   task automatic t_auto;
      apb(1, 12'h008, 32'h0000_0000);
      apb(1, 12'h03C, 32'h0000_0000);
      apb(1, 12'h008, 32'h0000_000B);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         if (adc_start === 1'b1) n++;
      end
      chk("adc pulses", 1, n >= 3);
      chk("masked irq", 0, irq);
      chk("adc seen", 1, n > 0);
      apb(1, 12'h008, 32'h0000_0000);
      $display("test auto done");
   endtask
   // center-aligned ch0: a zero every nine cycles, edge mode gives one every five
   task automatic t_center;
      apb(1, 12'h008, 32'h0000_000F);
      n = 0;
      repeat (40) begin
         @(posedge core_clk);
         if (adc_start === 1'b1) n++;
      end
      chk("center zeros", 1, n >= 3 && n <= 5);
      apb(1, 12'h008, 32'h0000_0000);
      $display("test center done");
   endtask
   // capture on ch1, rising edge with its enable
   task automatic t_capture;
      apb(1, 12'h010, 32'h0000_0010);
      apb(1, 12'h008, 32'h0000_0900);
      apb(1, 12'h03C, 32'h0000_0020);
      apb(1, 12'h034, 32'h000A_0000);
      repeat (2) @(posedge core_clk);
      chk("oe_n1", 1, pwm_oe_n[1]);
      src_lvl[1] <= 1'b1;
      wait_irq();
      apb(0, 12'h030, 0);
      chk("cap flag", 32'h20, rd & 32'h20);
      apb(0, 12'h044, 0);
      chk("rise latch", 1, rd <= 32'h10);
      $display("test capture done");
   endtask
   // pair mode on ch0/ch1, dead zone of one cycle; pins never high together
   task automatic t_pair;
      apb(1, 12'h034, 32'h0000_0000);
      apb(1, 12'h02C, 32'h0000_0001);
      apb(1, 12'h008, 32'h0000_0019);
      n = 0;
      rd = 32'h0000_0000;
      repeat (60) begin
         @(posedge core_clk);
         if (pwm_out[0] === 1'b1 && pwm_out[1] === 1'b1) n++;
         rd[1:0] = rd[1:0] | pwm_out[1:0];
      end
      chk("pair overlap", 0, n);
      chk("pair pins", 32'h0000_0003, rd);
      apb(1, 12'h008, 32'h0000_0000);
      $display("test pair done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial begin
      rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      src_lvl = 8'h00; miscompares = 0; check_count = 0; cyc = 0;
      repeat (5) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_oneshot();
      t_auto();
      t_center();
      t_capture();
      t_pair();
      end_sim();
   end
endmodule // tb_top
